// ===== tb/debug_service_register_unit_tb.sv
/* Self-checking bench for dsru_top over AXI4-Lite.
   Assumes the memory model answers at once or every other cycle. */
`timescale 1ns/1ns
`default_nettype none
module debug_service_register_unit_tb;
  // Identity codes are arbitrary
  localparam logic [31:0] ID_EXP = {4'h9, 5'h15, 1'b0, 6'h2A, 4'hC, 4'h3, 8'h7E};
  logic        aclk, aresetn, clk_en, protected_strap, write_guard, mem_valid, mem_req, irq, mem_slow;
  logic [31:0] mem_word, s_axi_wdata, s_axi_rdata;
  logic [29:0] mem_word_addr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_seen;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_count, cmp_count;
  dsru_top #(.PROCESSOR_CODE(4'h9), .FAMILY_CODE(5'h15), .SERIES_CODE(6'h2A), .DIE_CODE(4'hC),
    .REVISION_CODE(4'h3), .VARIANT_CODE(8'h7E)) dut (.*);
  dsru_mem_model mem (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = dsru_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, e});
  endtask : rc
  // Interrupt trails its status by one cycle
  task automatic ic(input logic e);
    repeat (2) @(posedge aclk);
    chk(irq, e);
  endtask : ic
  function automatic logic [31:0] crc_of(input logic [29:0] a, input logic [29:0] n, input logic [31:0] c);
    for (int i = 0; i < n; i++) begin
      c ^= {30'(a + i), 2'h3} ^ 32'h5A3C_96E1;
      for (int b = 0; b < 32; b++) c = c[0] ? (c >> 1) ^ dsru_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_of
  task automatic t_mailbox;
    wr(dsru_pkg::OFF_IRQ_MASK, 32'h0000_0002);
    wr(dsru_pkg::OFF_MAILBOX0, 32'hCAFE_0001);
    wr(dsru_pkg::OFF_MAILBOX1, 32'h0000_BEEF);
    ic(1'b1);
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_000D);
    rc(dsru_pkg::OFF_IRQ_STATUS, 32'h0000_0006);
    rc(dsru_pkg::OFF_MAILBOX0, 32'hCAFE_0001);
    wr(dsru_pkg::OFF_STATUS_B, 32'hFFFF_FFFF);
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_0009);
    wr(dsru_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    ic(1'b0);
    wr(dsru_pkg::OFF_IRQ_MASK, 32'h0000_0004);
    ic(1'b1);
    rc(dsru_pkg::OFF_MAILBOX1, 32'h0000_BEEF);
    wr(dsru_pkg::OFF_IRQ_STATUS, 32'h0000_0004);
    ic(1'b0);
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_0001);
  endtask : t_mailbox
  task automatic t_regs;
    wr(dsru_pkg::OFF_START_WORD, 32'hFFFF_FFFF);
    rc(dsru_pkg::OFF_START_WORD, 32'hFFFF_FFFC);
    wr(dsru_pkg::OFF_WORD_COUNT, 32'hFFFF_FFFF);
    rc(dsru_pkg::OFF_WORD_COUNT, 32'hFFFF_FFFC);
    write_guard <= 1'b1;
    protected_strap <= 1'b0;
    wr(dsru_pkg::OFF_START_WORD, 32'h0000_0010);
    rc(dsru_pkg::OFF_START_WORD, 32'hFFFF_FFFC);
    wr(dsru_pkg::OFF_MAILBOX1, 32'h0000_0033);
    rc(dsru_pkg::OFF_MAILBOX1, 32'h0000_0033);
    write_guard <= 1'b0;
    wr(dsru_pkg::OFF_IDENTITY, 32'h0000_0000);
    rc(dsru_pkg::OFF_IDENTITY, ID_EXP);
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_0001);
    rc(8'h40, 32'h0000_0000, dsru_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0000_0001);
    chk(bresp_seen, dsru_pkg::RESP_SLVERR);
  endtask : t_regs
  task automatic t_crc(input logic [29:0] s, input logic [29:0] n, input logic [31:0] seed, input logic slow);
    mem_slow <= slow;
    wr(dsru_pkg::OFF_START_WORD, {s, 2'h0});
    wr(dsru_pkg::OFF_WORD_COUNT, {n, 2'h0});
    wr(dsru_pkg::OFF_VALUE, seed);
    wr(dsru_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(dsru_pkg::OFF_CONTROL, 32'h0000_0004);
    rc(dsru_pkg::OFF_CONTROL, {30'h0, slow, 1'b0});
    for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge aclk);
    chk(irq, 1'b1);
    rc(dsru_pkg::OFF_VALUE, crc_of(s, n, seed));
    wr(dsru_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    ic(1'b0);
  endtask : t_crc
  task automatic t_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_0000);
    rc(dsru_pkg::OFF_START_WORD, 32'h0000_0000);
    ic(1'b0);
  endtask : t_reset
  // A write offered while frozen must wait, then land whole
  task automatic t_freeze;
    clk_en <= 1'b0;
    fork
      wr(dsru_pkg::OFF_MAILBOX0, 32'h5555_AAAA);
      begin
        repeat (3) @(posedge aclk);
        chk(s_axi_awready, 1'b0);
        clk_en <= 1'b1;
      end
    join
    rc(dsru_pkg::OFF_MAILBOX0, 32'h5555_AAAA);
    wr(dsru_pkg::OFF_MAILBOX0, 32'h1234_5678, 4'h6);
    rc(dsru_pkg::OFF_MAILBOX0, 32'h5534_56AA);
  endtask : t_freeze
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {write_guard, mem_slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {clk_en, protected_strap, s_axi_wstrb} = 6'h3F;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(dsru_pkg::OFF_STATUS_B, 32'h0000_0001);
    for (int o = 4; o <= 20; o += 4) rc(8'(o), 32'h0000_0000);
    t_mailbox();
    t_regs();
    t_crc(30'h0000_0010, 30'h3, 32'hFFFF_FFFF, 1'b0);
    t_crc(30'h3FFF_FFFE, 30'h4, 32'h0000_0000, 1'b1);
    t_crc(30'h0000_0005, 30'h0, 32'h1234_5678, 1'b0);
    t_reset();
    t_freeze();
    conclude();
  end
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule : debug_service_register_unit_tb
`default_nettype wire

// ===== tb/dsru_mem_model.sv
/* Memory feeding the checksum engine, one word per address.
   Assumes mem_req and mem_word_addr are registered by the unit. */
`timescale 1ns/1ns
`default_nettype none
module dsru_mem_model (
  input  wire logic        aclk,
  input  wire logic        mem_req,
  input  wire logic [29:0] mem_word_addr,
  input  wire logic        mem_slow,
  output logic [31:0]      mem_word,
  output logic             mem_valid
);
  logic gap = 1'b0;
  // Slow mode answers every other cycle to exercise waiting
  always_ff @(posedge aclk) gap <= mem_slow & ~gap;
  assign mem_valid = mem_req & ~gap;
  // Unqualified cycles show a different word so stale use is caught
  assign mem_word = {mem_word_addr, 2'h3} ^ (mem_valid ? 32'h5A3C_96E1 : 32'hA5C3_691E);
endmodule : dsru_mem_model
`default_nettype wire

// ===== tb/dsru_top_props.sv
/* Port checker for dsru_top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module dsru_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        mem_req,
  input wire logic        mem_valid,
  input wire logic [29:0] mem_word_addr,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // Frozen cycles would stretch every latency, so they are left out
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held high");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_r_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_r_pairs: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_mem_step: assert property (mem_req && mem_valid |=>
    !mem_req || mem_word_addr == $past(mem_word_addr) + 30'h1)
    else $error("word address not advanced");
  chk_mem_hold: assert property (mem_req && !mem_valid |=> $stable(mem_word_addr))
    else $error("word address moved");
  cover property (mem_req && mem_valid);
  cover property (mem_req && !mem_valid);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule : dsru_top_props
bind dsru_top dsru_top_props u_props (.*);
`default_nettype wire

// ===== verilog/dsru_pkg.sv
/*
  Package for the debug service register unit: register offsets, field
  positions, reset values, identity field layout and the AXI4-Lite carriers.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
`default_nettype none
package dsru_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS_B   = 8'h00;
  localparam logic [7:0] OFF_START_WORD = 8'h04;
  localparam logic [7:0] OFF_WORD_COUNT = 8'h08;
  localparam logic [7:0] OFF_VALUE      = 8'h0C;
  localparam logic [7:0] OFF_MAILBOX0   = 8'h10;
  localparam logic [7:0] OFF_MAILBOX1   = 8'h14;
  localparam logic [7:0] OFF_IDENTITY   = 8'h18;
  localparam logic [7:0] OFF_CONTROL    = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h24;
  localparam int unsigned BIT_SECURED = 0;
  localparam int unsigned BIT_DIRTY0  = 2;
  localparam int unsigned BIT_DIRTY1  = 3;
  localparam int unsigned BIT_CRC_GO  = 2;
  localparam int unsigned BIT_DONE    = 0;
  localparam int unsigned BIT_EV_MB0  = 1;
  localparam int unsigned BIT_EV_MB1  = 2;
  localparam int unsigned IRQ_BITS    = 3;
  localparam int unsigned WORD_LSB    = 2;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
  localparam int unsigned ID_PROC_LSB = 28;
  localparam int unsigned ID_FAM_LSB  = 23;
  localparam int unsigned ID_SER_LSB  = 16;
  localparam int unsigned ID_DIE_LSB  = 12;
  localparam int unsigned ID_REV_LSB  = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } dsru_wreq_type;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } dsru_rresp_type;

  typedef enum logic [1:0] {
    DSRU_IDLE = 2'b00,
    DSRU_RUN  = 2'b01,
    DSRU_DONE = 2'b11
  } dsru_op_type;
endpackage : dsru_pkg
`default_nettype wire

// ===== verilog/dsru_top.sv
/*
  Debug service register unit: protection flag, two debug mailboxes with
  dirty flags, memory-operation start word, word count and value registers,
  identity register, a checksum engine and a masked interrupt, all behind an
  AXI4-Lite slave. Assumes one clock, synchronous active-low reset, and that
  the memory being checked is fed word by word on mem_word/mem_valid.
*/
// Operation
// - Secured flag captured at power-up when protected
// - Secured flag cleared only by reset, writes ignored
// - Dirty flag set on mailbox write
// - Dirty flag cleared on mailbox read
// - Start word register, bits 31:2, reset zero
// - Word count register, bits 31:2, reset zero
// - Value register seeds and returns result
// - Mailbox zero, read/write, unguarded, reset zero
// - Mailbox one, read/write, unguarded, reset zero
// - Identity bits 31:28 report processor code
// - Identity read-only with ordering fields
// - Start bit launches checksum over range
// - Done set on finish, write one clears
`timescale 1ns/1ns
`default_nettype none
module dsru_top #(
  parameter logic [3:0] PROCESSOR_CODE = 4'h1, // Arbitrary value
  parameter logic [4:0] FAMILY_CODE    = 5'h02, // Arbitrary value
  parameter logic [5:0] SERIES_CODE    = 6'h03, // Arbitrary value
  parameter logic [3:0] DIE_CODE       = 4'h4, // Arbitrary value
  parameter logic [3:0] REVISION_CODE  = 4'h5, // Arbitrary value
  parameter logic [7:0] VARIANT_CODE   = 8'h06  // Arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        protected_strap,
  input  wire logic        write_guard,
  input  wire logic [31:0] mem_word,
  input  wire logic        mem_valid,
  output logic             mem_req,
  output logic [29:0]      mem_word_addr,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // The read decode and the write strobes assume an eight-bit byte address
  if (dsru_pkg::ADDR_W != 8) begin : g_bad_addr_width
    $error("address width must be eight bits");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Word-aligned fields keep bits 1:0 at zero whatever the strobes say
  function automatic logic [29:0] merge_word(input logic [29:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = merge({old, 2'b00}, nw, be);
    return m[31:dsru_pkg::WORD_LSB];
  endfunction : merge_word

  function automatic logic known(input logic [7:0] a);
    return a == dsru_pkg::OFF_STATUS_B || a == dsru_pkg::OFF_START_WORD || a == dsru_pkg::OFF_WORD_COUNT
        || a == dsru_pkg::OFF_VALUE || a == dsru_pkg::OFF_MAILBOX0 || a == dsru_pkg::OFF_MAILBOX1
        || a == dsru_pkg::OFF_IDENTITY || a == dsru_pkg::OFF_CONTROL || a == dsru_pkg::OFF_IRQ_STATUS
        || a == dsru_pkg::OFF_IRQ_MASK;
  endfunction : known

  dsru_pkg::dsru_wreq_type  wreq;
  dsru_pkg::dsru_rresp_type rres;
  logic        aw_held;
  logic        w_held;
  logic        wr_fire;
  logic        rd_fire;
  logic        secured;
  logic        strap_taken;
  logic        dirty0;
  logic        dirty1;
  logic [29:0] start_word;
  logic [29:0] word_count;
  logic [31:0] op_value;
  logic [31:0] mailbox0;
  logic [31:0] mailbox1;
  logic [29:0] words_left;
  logic [dsru_pkg::IRQ_BITS-1:0] irq_status;
  logic [dsru_pkg::IRQ_BITS-1:0] irq_mask;
  logic [dsru_pkg::IRQ_BITS-1:0] events;
  dsru_pkg::dsru_op_type op_state;
  logic [31:0] identity;
  logic [31:0] next_crc;
  logic        guarded_ok;
  logic        start_cmd;
  logic        op_finish;
  logic        wr_start_word;
  logic        wr_word_count;
  logic        wr_value;
  logic        wr_mailbox0;
  logic        wr_mailbox1;
  logic        wr_control;
  logic        wr_irq_status;
  logic        wr_irq_mask;
  logic        rd_mailbox0;
  logic        rd_mailbox1;

  // Bit 22 carries no field and reads zero
  always_comb begin
    identity                             = 32'h0000_0000;
    identity[dsru_pkg::ID_PROC_LSB +: 4] = PROCESSOR_CODE;
    identity[dsru_pkg::ID_FAM_LSB +: 5]  = FAMILY_CODE;
    identity[dsru_pkg::ID_SER_LSB +: 6]  = SERIES_CODE;
    identity[dsru_pkg::ID_DIE_LSB +: 4]  = DIE_CODE;
    identity[dsru_pkg::ID_REV_LSB +: 4]  = REVISION_CODE;
    identity[7:0]                        = VARIANT_CODE;
  end

  // A write waits while its response is still pending
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign guarded_ok = !write_guard;

  // Strobes decoded once so every register block agrees on the target
  assign wr_start_word = wr_fire && wreq.addr == dsru_pkg::OFF_START_WORD;
  assign wr_word_count = wr_fire && wreq.addr == dsru_pkg::OFF_WORD_COUNT;
  assign wr_value      = wr_fire && wreq.addr == dsru_pkg::OFF_VALUE;
  assign wr_mailbox0   = wr_fire && wreq.addr == dsru_pkg::OFF_MAILBOX0;
  assign wr_mailbox1   = wr_fire && wreq.addr == dsru_pkg::OFF_MAILBOX1;
  assign wr_control    = wr_fire && wreq.addr == dsru_pkg::OFF_CONTROL;
  assign wr_irq_status = wr_fire && wreq.addr == dsru_pkg::OFF_IRQ_STATUS;
  assign wr_irq_mask   = wr_fire && wreq.addr == dsru_pkg::OFF_IRQ_MASK;
  assign rd_mailbox0   = rd_fire && s_axi_araddr[7:2] == dsru_pkg::OFF_MAILBOX0[7:2];
  assign rd_mailbox1   = rd_fire && s_axi_araddr[7:2] == dsru_pkg::OFF_MAILBOX1[7:2];

  assign start_cmd = wr_control && guarded_ok && wreq.strb[0]
                     && wreq.data[dsru_pkg::BIT_CRC_GO] && op_state != dsru_pkg::DSRU_RUN;
  assign op_finish = op_state == dsru_pkg::DSRU_RUN && (words_left == 30'h0
                     || (mem_valid && words_left == 30'h1));

  // Write channel: address and data taken in either order
  // Ready pulses for one cycle so a held valid is never taken twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wreq          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dsru_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        wreq.addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held    <= 1'b1;
        wreq.data <= s_axi_wdata;
        wreq.strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(wreq.addr) ? dsru_pkg::RESP_OKAY : dsru_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_comb begin
    rres.resp = dsru_pkg::RESP_OKAY;
    case ({s_axi_araddr[7:2], 2'b00})
      dsru_pkg::OFF_STATUS_B:   rres.data = {28'h0, dirty1, dirty0, 1'b0, secured};
      dsru_pkg::OFF_START_WORD: rres.data = {start_word, 2'b00};
      dsru_pkg::OFF_WORD_COUNT: rres.data = {word_count, 2'b00};
      dsru_pkg::OFF_VALUE:      rres.data = op_value;
      dsru_pkg::OFF_MAILBOX0:   rres.data = mailbox0;
      dsru_pkg::OFF_MAILBOX1:   rres.data = mailbox1;
      dsru_pkg::OFF_IDENTITY:   rres.data = identity;
      dsru_pkg::OFF_CONTROL:    rres.data = {30'h0, op_state == dsru_pkg::DSRU_RUN, 1'b0};
      dsru_pkg::OFF_IRQ_STATUS: rres.data = {29'h0, irq_status};
      dsru_pkg::OFF_IRQ_MASK:   rres.data = {29'h0, irq_mask};
      default: begin
        rres.data = 32'h0;
        rres.resp = dsru_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= dsru_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rres.data;
        s_axi_rresp  <= rres.resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Strap is sampled once after reset release, never from the reset branch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secured     <= 1'b0;
      strap_taken <= 1'b0;
    end else if (clk_en && !strap_taken) begin
      strap_taken <= 1'b1;
      secured     <= protected_strap;
    end
  end

  // Mailboxes ignore the write guard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mailbox0 <= dsru_pkg::RESET_WORD;
      mailbox1 <= dsru_pkg::RESET_WORD;
    end else if (clk_en && wr_fire) begin
      if (wr_mailbox0) mailbox0 <= merge(mailbox0, wreq.data, wreq.strb);
      if (wr_mailbox1) mailbox1 <= merge(mailbox1, wreq.data, wreq.strb);
    end
  end

  // Set wins over clear when a write and a read meet in one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dirty0 <= 1'b0;
      dirty1 <= 1'b0;
    end else if (clk_en) begin
      if (wr_mailbox0) dirty0 <= 1'b1;
      else if (rd_mailbox0) dirty0 <= 1'b0;
      if (wr_mailbox1) dirty1 <= 1'b1;
      else if (rd_mailbox1) dirty1 <= 1'b0;
    end
  end

  // Operation setup registers, held off by the write guard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_word <= dsru_pkg::RESET_WORD[31:2];
      word_count <= dsru_pkg::RESET_WORD[31:2];
    end else if (clk_en && wr_fire && guarded_ok) begin
      if (wr_start_word)
        start_word <= merge_word(start_word, wreq.data, wreq.strb);
      if (wr_word_count)
        word_count <= merge_word(word_count, wreq.data, wreq.strb);
    end
  end

  // Reflected CRC-32 step over one word
  always_comb begin
    next_crc = op_value ^ mem_word;
    for (int i = 0; i < 32; i++) begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ dsru_pkg::CRC_POLY) : (next_crc >> 1);
    end
  end

  // Checksum engine; value register is seed before and result after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_state      <= dsru_pkg::DSRU_IDLE;
      op_value      <= dsru_pkg::RESET_WORD;
      words_left    <= 30'h0;
      mem_req       <= 1'b0;
      mem_word_addr <= 30'h0;
    end else if (clk_en) begin
      case (op_state)
        // A count of zero finishes at once without fetching a word
        dsru_pkg::DSRU_RUN: begin
          if (mem_valid && words_left != 30'h0) begin
            op_value      <= next_crc;
            words_left    <= words_left - 30'h1;
            mem_word_addr <= mem_word_addr + 30'h1;
          end
          if (op_finish) begin
            op_state <= dsru_pkg::DSRU_DONE;
            mem_req  <= 1'b0;
          end
        end
        default: begin
          if (start_cmd) begin
            op_state      <= dsru_pkg::DSRU_RUN;
            words_left    <= word_count;
            mem_word_addr <= start_word;
            mem_req       <= 1'b1;
          end else if (wr_value && guarded_ok) begin
            op_value <= merge(op_value, wreq.data, wreq.strb);
          end
        end
      endcase
    end
  end

  // Sticky interrupt status, write one to clear, new events win
  assign events = {!dirty1 && wr_mailbox1,
                   !dirty0 && wr_mailbox0,
                   op_finish};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr_irq_status && wreq.strb[0])
        irq_status <= (irq_status & ~wreq.data[dsru_pkg::IRQ_BITS-1:0]) | events;
      else
        irq_status <= irq_status | events;
      if (wr_irq_mask && wreq.strb[0])
        irq_mask <= wreq.data[dsru_pkg::IRQ_BITS-1:0];
      // Registered so the pin comes straight from a flip-flop
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule : dsru_top
`default_nettype wire
